// >>> inc/sys_cfg_pkg.sv
// package: offsets, fields, reset values and types of the system configuration bank
package sys_cfg_pkg;
    localparam logic [7:0] OFS_PAN = 8'h18;
    localparam logic [7:0] OFS_CLK_DIV = 8'h19;
    localparam logic [7:0] OFS_POWER = 8'h1A;
    localparam logic [7:0] OFS_IF_DIS = 8'h1B;
    localparam logic [7:0] OFS_STRAP_LO = 8'h1C;
    localparam logic [7:0] OFS_STRAP_HI = 8'h1D;
    localparam logic [7:0] OFS_DIR_LO = 8'h1E;
    localparam logic [7:0] OFS_DIR_HI = 8'h1F;
    localparam logic [7:0] OFS_STATE_LO = 8'h20;
    localparam logic [7:0] OFS_STATE_HI = 8'h21;
    localparam logic [7:0] OFS_OPEN_LO = 8'h28;
    localparam logic [7:0] OFS_OPEN_HI = 8'h2F;
    // field positions
    localparam int PAN_S2_LSB = 4;
    localparam int MCLK_DIV_BIT = 2;
    localparam int IF_DIS_BIT = 7;
    localparam int HFB_DIS_BIT = 0;
    localparam int POL_STRAP_BIT = 10;
    localparam int DAC_STRAP_BIT = 8;
    localparam int MEMCFG_STRAP_LSB = 6;
    localparam int GPIO_DAC_LSB = 4;
    localparam int GPIO_MEM_LSB = 1;
    localparam int GPIO_MEM_MSB = 3;
    // reset values
    localparam logic [7:0] RST_PAN = 8'h00;
    localparam logic [7:0] RST_CLK_DIV = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_IF_DIS = 8'h80;
    localparam logic [11:0] RST_DIR = 12'h000;
    localparam logic [11:0] RST_STATE = 12'h000;
    // bits-per-pixel select codes
    localparam logic [2:0] BPP_1 = 3'h0;
    localparam logic [2:0] BPP_2 = 3'h1;
    localparam logic [2:0] BPP_4 = 3'h2;
    localparam logic [2:0] BPP_8 = 3'h3;

    typedef struct packed {
        logic [3:0] unused;
        logic panel_pwr_dis;
        logic [1:0] refresh_sel;
        logic sw_suspend;
    } power_save_t;

    typedef struct packed {
        logic [1:0] unused;
        logic mclk_half;
        logic [1:0] pclk_div;
    } clock_div_t;

    typedef enum logic [1:0] {REF_CBR, REF_SELF, REF_NONE} refresh_t;
endpackage

// >>> design/system_config_register_bank.sv
// system configuration register bank: panning, clock dividers, power save, gpio
//
// Notes on behaviour
// - pan register: high nibble screen 2, low screen 1
// - each screen shifts left by its pan
// - pan bits used: 4 at 1bpp, 3/2bpp, 2/4bpp
// - memory clock halves when divide bit set
// - pixel clock divides memory clock 1 to 4
// - panel power disable forces output off
// - panel power polarity from strap at reset
// - suspend refresh: cbr, self, or none
// - software suspend follows its enable bit
// - host interface disable resets to one
// - disabled host reaches only listed registers
// - half frame buffer follows disable bit
// - single panel always disables half frame buffer
// - sixteen straps captured at reset, read back
// - direction bit one output, zero input
// - pins 4 to 11 need dac strap high
// - pins 1 to 3 need memory straps equal to MEMCFG_GPIO_CODE
// - output drives state bit, input reads pin
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module system_config_register_bank
    import sys_cfg_pkg::*;
#(
    parameter int GPIO_COUNT = 12,
    parameter logic [1:0] MEMCFG_GPIO_CODE = 2'h0
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // display context
    input wire logic [2:0] i_bpp_sel,
    input wire logic i_single_panel,
    input wire logic i_panel_seq_on,
    // strap pins
    input wire logic [15:0] i_strap_pins,
    // general purpose pins and their shared functions
    input wire logic [11:0] i_gpio_in,
    input wire logic [11:0] i_alt_func_out,
    output logic [11:0] o_gpio_out,
    output logic [11:0] o_gpio_oe_n,
    // clock enables
    output logic o_mem_clk_en,
    output logic o_pix_clk_en,
    // panning
    output logic [3:0] o_pan_shift_s1,
    output logic [3:0] o_pan_shift_s2,
    // power and misc
    output logic o_panel_power_out,
    output logic o_suspend_active,
    output logic o_cbr_refresh,
    output logic o_self_refresh,
    output logic o_half_fb_enable,
    output logic o_host_if_enabled
);

    if (GPIO_COUNT != 12) begin : g_bad_count
        $error("gpio count must be 12");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [3:0] pan_mask(input logic [2:0] bpp, input logic [3:0] pan);
        logic [3:0] m;
        m = 4'h0;
        case (bpp)
            BPP_1: m = 4'hF;
            BPP_2: m = 4'h7;
            BPP_4: m = 4'h3;
            BPP_8: m = 4'h1;
            default: m = 4'h0;
        endcase
        return pan & m;
    endfunction

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] pan_ff;
    clock_div_t clk_div_ff;
    power_save_t power_ff;
    logic host_dis_ff;
    logic hfb_dis_ff;
    logic [11:0] dir_ff;
    logic [11:0] state_ff;
    logic [15:0] strap_meta_ff;
    logic [15:0] strap_sync_ff;
    logic [15:0] strap_ff;
    logic strap_done_ff;
    logic [11:0] gpio_meta_ff;
    logic [11:0] gpio_sync_ff;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] nxt_rdata;

    // host access gate while the host interface is disabled
    always_comb begin
        wr_ok = i_wr && (!host_dis_ff || (i_addr == OFS_IF_DIS));
        rd_ok = i_rd && (!host_dis_ff || (i_addr == OFS_IF_DIS) || (i_addr == OFS_POWER)
                || in_range(i_addr, OFS_OPEN_LO, OFS_OPEN_HI));
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pan_ff <= RST_PAN;
        end else if (wr_ok && (i_addr == OFS_PAN)) begin
            pan_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            clk_div_ff <= clock_div_t'(RST_CLK_DIV[4:0]);
        end else if (wr_ok && (i_addr == OFS_CLK_DIV)) begin
            clk_div_ff <= {2'h0, i_wdata[MCLK_DIV_BIT:0]};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            power_ff <= power_save_t'(RST_POWER);
        end else if (wr_ok && (i_addr == OFS_POWER)) begin
            power_ff <= power_save_t'({4'h0, i_wdata[3:0]});
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            host_dis_ff <= RST_IF_DIS[IF_DIS_BIT];
            hfb_dis_ff <= RST_IF_DIS[HFB_DIS_BIT];
        end else if (wr_ok && (i_addr == OFS_IF_DIS)) begin
            host_dis_ff <= i_wdata[IF_DIS_BIT];
            hfb_dis_ff <= i_wdata[HFB_DIS_BIT];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_ff <= RST_DIR;
        end else if (wr_ok && (i_addr == OFS_DIR_LO)) begin
            dir_ff[7:0] <= i_wdata;
        end else if (wr_ok && (i_addr == OFS_DIR_HI)) begin
            dir_ff[11:8] <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= RST_STATE;
        end else if (wr_ok && (i_addr == OFS_STATE_LO)) begin
            state_ff[7:0] <= i_wdata;
        end else if (wr_ok && (i_addr == OFS_STATE_HI)) begin
            state_ff[11:8] <= i_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture: synchroniser runs through reset, first edge after release latches

    always_ff @(posedge i_mclk) begin
        strap_meta_ff <= i_strap_pins;
        strap_sync_ff <= strap_meta_ff;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_ff <= 16'h0000;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_ff <= strap_sync_ff;
            strap_done_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            gpio_meta_ff <= 12'h000;
            gpio_sync_ff <= 12'h000;
        end else begin
            gpio_meta_ff <= i_gpio_in;
            gpio_sync_ff <= gpio_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [11:0] gpio_readback;

    always_comb begin
        gpio_readback = (dir_ff & state_ff) | (~dir_ff & gpio_sync_ff);
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_ok) begin
            case (i_addr)
                OFS_PAN: nxt_rdata = pan_ff;
                OFS_CLK_DIV: nxt_rdata = {3'h0, clk_div_ff};
                OFS_POWER: nxt_rdata = power_ff;
                OFS_IF_DIS: nxt_rdata = {host_dis_ff, 6'h00, hfb_dis_ff};
                OFS_STRAP_LO: nxt_rdata = strap_ff[7:0];
                OFS_STRAP_HI: nxt_rdata = strap_ff[15:8];
                OFS_DIR_LO: nxt_rdata = dir_ff[7:0];
                OFS_DIR_HI: nxt_rdata = {4'h0, dir_ff[11:8]};
                OFS_STATE_LO: nxt_rdata = gpio_readback[7:0];
                OFS_STATE_HI: nxt_rdata = {4'h0, gpio_readback[11:8]};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock enables

    logic mclk_tgl_ff;
    logic [1:0] pix_cnt_ff;
    logic mem_tick;

    always_comb begin
        mem_tick = clk_div_ff.mclk_half ? mclk_tgl_ff : 1'b1;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mclk_tgl_ff <= 1'b0;
        end else begin
            mclk_tgl_ff <= ~mclk_tgl_ff;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pix_cnt_ff <= 2'h0;
        end else if (mem_tick) begin
            pix_cnt_ff <= (pix_cnt_ff >= clk_div_ff.pclk_div) ? 2'h0 : pix_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mem_clk_en <= 1'b0;
            o_pix_clk_en <= 1'b0;
        end else begin
            o_mem_clk_en <= mem_tick;
            o_pix_clk_en <= mem_tick && (pix_cnt_ff >= clk_div_ff.pclk_div);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // panning

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pan_shift_s1 <= 4'h0;
            o_pan_shift_s2 <= 4'h0;
        end else begin
            o_pan_shift_s1 <= pan_mask(i_bpp_sel, pan_ff[PAN_S2_LSB-1:0]);
            o_pan_shift_s2 <= pan_mask(i_bpp_sel, pan_ff[7:PAN_S2_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power save and misc

    refresh_t refresh_mode;
    logic pwr_on_level;

    always_comb begin
        case (power_ff.refresh_sel)
            2'h0: refresh_mode = REF_CBR;
            2'h1: refresh_mode = REF_SELF;
            default: refresh_mode = REF_NONE;
        endcase
        pwr_on_level = strap_ff[POL_STRAP_BIT];
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_panel_power_out <= 1'b0;
        end else if (power_ff.panel_pwr_dis || !i_panel_seq_on) begin
            o_panel_power_out <= ~pwr_on_level;
        end else begin
            o_panel_power_out <= pwr_on_level;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_suspend_active <= 1'b0;
            o_cbr_refresh <= 1'b0;
            o_self_refresh <= 1'b0;
        end else begin
            o_suspend_active <= power_ff.sw_suspend;
            o_cbr_refresh <= power_ff.sw_suspend && (refresh_mode == REF_CBR);
            o_self_refresh <= power_ff.sw_suspend && (refresh_mode == REF_SELF);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_half_fb_enable <= 1'b0;
            o_host_if_enabled <= 1'b0;
        end else begin
            o_half_fb_enable <= !hfb_dis_ff && !i_single_panel;
            o_host_if_enabled <= !host_dis_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general purpose pins

    logic [11:0] gpio_func;

    always_comb begin
        gpio_func = 12'h001;
        gpio_func[11:GPIO_DAC_LSB] = {8{strap_ff[DAC_STRAP_BIT]}};
        gpio_func[GPIO_MEM_MSB:GPIO_MEM_LSB] =
            {3{strap_ff[MEMCFG_STRAP_LSB+1:MEMCFG_STRAP_LSB] == MEMCFG_GPIO_CODE}};
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_gpio_out <= 12'h000;
            o_gpio_oe_n <= 12'hFFF;
        end else begin
            o_gpio_out <= (gpio_func & state_ff) | (~gpio_func & i_alt_func_out);
            o_gpio_oe_n <= gpio_func & ~dir_ff;
        end
    end

endmodule

// >>> verification/system_config_register_bank_assertions.sv
// checker: concurrent assertions on the configuration bank ports
`timescale 1ns/100ps
module system_config_register_bank_assertions (
    // clock, reset, register port
    input logic i_mclk,
    input logic i_rstn,
    input logic [7:0] i_addr,
    input logic [7:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    input logic [7:0] o_rdata,
    // context and outputs
    input logic [2:0] i_bpp_sel,
    input logic i_single_panel,
    input logic o_mem_clk_en,
    input logic o_pix_clk_en,
    input logic [3:0] o_pan_shift_s1,
    input logic [3:0] o_pan_shift_s2,
    input logic o_suspend_active,
    input logic o_cbr_refresh,
    input logic o_self_refresh,
    input logic o_half_fb_enable,
    input logic o_host_if_enabled
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    sequence s_wr(a);
        i_wr && i_addr == a;
    endsequence
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence
    //////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_host_enable: assert property (s_wr(8'h1B) |-> ##2
        o_host_if_enabled == !$past(i_wdata[7], 2)) else $error("host enable wrong");
    a_read_blocked: assert property (s_rd(8'h18) ##1 !o_host_if_enabled
        |-> o_rdata == 8'h00) else $error("read not blocked");
    a_unused_bits: assert property (s_rd(8'h19) |=> o_rdata[7:3] == 5'h00)
        else $error("unused clock bits not zero");
    a_refresh_suspend: assert property (o_cbr_refresh || o_self_refresh
        |-> o_suspend_active) else $error("refresh outside suspend");
    a_refresh_excl: assert property (!(o_cbr_refresh && o_self_refresh))
        else $error("two refresh kinds at once");
    a_pix_mem: assert property (o_pix_clk_en |-> o_mem_clk_en)
        else $error("pixel tick without memory tick");
    a_hfb_single: assert property (i_single_panel [*3] |=> !o_half_fb_enable)
        else $error("half frame buffer on with single panel");
    a_pan_mask: assert property (i_bpp_sel == 3'h2 |=>
        o_pan_shift_s1[3:2] == 2'h0 && o_pan_shift_s2[3:2] == 2'h0)
        else $error("pan not masked at 4bpp");
endmodule

// >>> verification/system_config_register_bank_bench.sv
// bench: directed scenarios for the configuration register bank
`timescale 1ns/100ps
module system_config_register_bank_bench
    import sys_cfg_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [2:0] i_bpp_sel = 3'h0;
    logic i_single_panel = 1'b0;
    logic i_panel_seq_on = 1'b1;
    logic [15:0] i_strap_pins = 16'h0503;
    logic [11:0] i_gpio_in = 12'h5A3;
    logic [11:0] i_alt_func_out = 12'hC35;
    logic [7:0] o_rdata;
    logic [11:0] o_gpio_out;
    logic [11:0] o_gpio_oe_n;
    logic o_mem_clk_en, o_pix_clk_en, o_panel_power_out, o_suspend_active;
    logic o_cbr_refresh, o_self_refresh, o_half_fb_enable, o_host_if_enabled;
    logic [3:0] o_pan_shift_s1;
    logic [3:0] o_pan_shift_s2;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;

    system_config_register_bank system_config_register_bank_inst (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bpp_sel(i_bpp_sel),
        .i_single_panel(i_single_panel), .i_panel_seq_on(i_panel_seq_on),
        .i_strap_pins(i_strap_pins), .i_gpio_in(i_gpio_in),
        .i_alt_func_out(i_alt_func_out), .o_gpio_out(o_gpio_out),
        .o_gpio_oe_n(o_gpio_oe_n), .o_mem_clk_en(o_mem_clk_en),
        .o_pix_clk_en(o_pix_clk_en), .o_pan_shift_s1(o_pan_shift_s1),
        .o_pan_shift_s2(o_pan_shift_s2), .o_panel_power_out(o_panel_power_out),
        .o_suspend_active(o_suspend_active), .o_cbr_refresh(o_cbr_refresh),
        .o_self_refresh(o_self_refresh), .o_half_fb_enable(o_half_fb_enable),
        .o_host_if_enabled(o_host_if_enabled));

    initial forever #25 i_mclk = ~i_mclk;
    //////////////////////////////////////////////
    task automatic results;
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, o_rdata});
    endtask
    //////////////////////////////////////////////
    task automatic t_locked;
        chk("host enabled", 12'h000, {11'h0, o_host_if_enabled});
        rd(OFS_IF_DIS, 8'h80);
        wr(OFS_PAN, 8'hFF);
        rd(OFS_STRAP_LO, 8'h00);
        rd(OFS_PAN, 8'h00);
        wr(OFS_IF_DIS, 8'h00);
        wt(2);
        chk("host enabled", 12'h001, {11'h0, o_host_if_enabled});
        rd(OFS_PAN, 8'h00);
        rd(OFS_STRAP_LO, 8'h03);
        rd(OFS_STRAP_HI, 8'h05);
        rd(8'h30, 8'h00);
    endtask
    task automatic t_pan;
        logic [3:0] m;
        wr(OFS_PAN, 8'hA5);
        for (int b = 0; b < 6; b++) begin
            m = (b == 0) ? 4'hF : (b == 1) ? 4'h7 : (b == 2) ? 4'h3 : (b == 3) ? 4'h1 : 4'h0;
            i_bpp_sel <= 3'(b);
            wt(3);
            chk("pan s1", {8'h0, 4'h5 & m}, {8'h0, o_pan_shift_s1});
            chk("pan s2", {8'h0, 4'hA & m}, {8'h0, o_pan_shift_s2});
        end
    endtask
    task automatic t_clk;
        int m;
        int p;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CLK_DIV, 8'(c));
            rd(OFS_CLK_DIV, 8'(c));
            wt(10);
            m = 0;
            p = 0;
            repeat (24) begin
                @(posedge i_mclk);
                m += (o_mem_clk_en === 1'b1);
                p += (o_pix_clk_en === 1'b1);
            end
            chk("mem ticks", c[2] ? 12'h00C : 12'h018, 12'(m));
            chk("pix ticks", 12'((c[2] ? 12 : 24) / (c % 4 + 1)), 12'(p));
        end
    endtask
    task automatic t_power;
        for (int v = 0; v < 8; v++) begin
            wr(OFS_POWER, 8'(v & 6));
            wr(OFS_POWER, 8'(v));
            wt(3);
            chk("suspend", {9'h0, v[0], v[0] && v[2:1] == 0, v[0] && v[2:1] == 1},
                {9'h0, o_suspend_active, o_cbr_refresh, o_self_refresh});
        end
        wr(OFS_POWER, 8'hF8);
        rd(OFS_POWER, 8'h08);
        wt(3);
        chk("panel power", 12'h000, {11'h0, o_panel_power_out});
        wr(OFS_POWER, 8'h00);
        wt(3);
        chk("panel power", 12'h001, {11'h0, o_panel_power_out});
    endtask
    task automatic t_hfb;
        wr(OFS_POWER, 8'h01);
        wr(OFS_IF_DIS, 8'h01);
        wt(3);
        chk("half fb", 12'h000, {11'h0, o_half_fb_enable});
        wr(OFS_IF_DIS, 8'h00);
        wt(3);
        chk("half fb", 12'h001, {11'h0, o_half_fb_enable});
        i_single_panel <= 1'b1;
        wt(5);
        chk("half fb", 12'h000, {11'h0, o_half_fb_enable});
        i_single_panel <= 1'b0;
        wr(OFS_POWER, 8'h00);
    endtask
    task automatic t_gpio;
        wr(OFS_DIR_LO, 8'hFF);
        wr(OFS_DIR_HI, 8'hFF);
        wr(OFS_STATE_LO, 8'hA5);
        wr(OFS_STATE_HI, 8'h06);
        rd(OFS_DIR_HI, 8'h0F);
        wt(3);
        chk("pin oe", 12'h000, o_gpio_oe_n);
        chk("pin out", 12'h6A5, o_gpio_out);
        wr(OFS_DIR_LO, 8'h00);
        wr(OFS_DIR_HI, 8'h00);
        wt(3);
        chk("pin oe", 12'hFFF, o_gpio_oe_n);
        rd(OFS_STATE_LO, 8'hA3);
        rd(OFS_STATE_HI, 8'h05);
    endtask
    task automatic t_shared;
        i_rstn <= 1'b0;
        i_strap_pins <= 16'h0040;
        wt(4);
        i_rstn <= 1'b1;
        wr(OFS_POWER, 8'h01);
        wr(OFS_IF_DIS, 8'h00);
        wt(3);
        chk("pin oe", 12'h001, o_gpio_oe_n);
        chk("pin out", 12'hC34, o_gpio_out & 12'hFFE);
        rd(OFS_STRAP_LO, 8'h40);
        rd(OFS_POWER, 8'h00);
        chk("panel power", 12'h000, {11'h0, o_panel_power_out});
        i_panel_seq_on <= 1'b0;
        wt(3);
        chk("panel power", 12'h001, {11'h0, o_panel_power_out});
        i_panel_seq_on <= 1'b1;
    endtask
    //////////////////////////////////////////////
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_locked();
        t_pan();
        t_clk();
        t_power();
        t_hfb();
        t_gpio();
        t_shared();
        results();
    end
endmodule

bind system_config_register_bank system_config_register_bank_assertions
    system_config_register_bank_assertions_inst (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bpp_sel(i_bpp_sel),
    .i_single_panel(i_single_panel), .o_mem_clk_en(o_mem_clk_en),
    .o_pix_clk_en(o_pix_clk_en), .o_pan_shift_s1(o_pan_shift_s1),
    .o_pan_shift_s2(o_pan_shift_s2), .o_suspend_active(o_suspend_active),
    .o_cbr_refresh(o_cbr_refresh), .o_self_refresh(o_self_refresh),
    .o_half_fb_enable(o_half_fb_enable), .o_host_if_enabled(o_host_if_enabled));
